/* design/lvd_ctrl.sv */
// Top of the low-voltage detect control: registers, reset and interrupt generation
module lvd_ctrl (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       lowv_reset_in,
	// Register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Comparators
	input  wire logic       supply_below_raw,
	input  wire logic       ext_sense_pin_below_raw,
	// Outputs
	output logic      [3:0] supply_threshold,
	output logic            cmp_enable,
	output logic            lowv_reset_req,
	output logic            lowv_irq
);
	// Operation
	// - Supply source, reset mode: reset while below
	// - Pin source, reset mode: reset while below
	// - Interrupt mode: request on both crossings
	// - Enabled detector shows below flag bit 0
	// - Mode bit1, source bit2, enable bit7
	// - Level code in bits 3:0
	// - No reset when already above threshold
	// - Unmasked enable may interrupt at once
	// - Disable while below in interrupt mode raises interrupt
	// - Every reset sets interrupt mask
	// - Detector reset recorded in cause bit 0
	// - Control bits survive only detector reset
	// - Level survives only detector reset
	//
	// lowv_reset_in is the chip reset caused by this detector; sys_rst is every other reset.

	// ****************************************
	// State
	// ****************************************
	logic       on_reg, on_next;         // Detector on
	logic       mode_reg, mode_next;     // Reset-not-interrupt select
	logic       src_reg, src_next;       // Sense source select
	logic [3:0] level_reg, level_next;   // Level code
	logic       mask_reg, mask_next;     // Interrupt mask
	logic       req_reg, req_next;       // Interrupt request flag
	logic       cause_reg, cause_next;   // Detector reset cause
	logic       irq_reg, irq_next;       // Interrupt pulse
	logic       rst_reg, rst_next;       // Reset request level
	logic [7:0] rdata_reg, rdata_next;   // Read data
	logic       irq_evt;                 // Interrupt event this cycle
	logic       cmp_raw;                 // Selected raw comparator
	logic       any_rst;                 // Any reset

	lvd_cmp_if cmp ();

	// Source mux ahead of the synchroniser; a source change may look like an edge,
	// which is why software masks before choosing the source.
	assign cmp_raw = src_reg ? ext_sense_pin_below_raw : supply_below_raw;
	assign any_rst = sys_rst | lowv_reset_in;

	lvd_sync #(.STAGES(lvd_pkg::SYNC_STAGES)) u_sync (
		.mclk    (mclk),
		.sys_rst (any_rst),
		.cmp_raw (cmp_raw),
		.cmp     (cmp)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		on_next    = on_reg;
		mode_next  = mode_reg;
		src_next   = src_reg;
		level_next = level_reg;
		mask_next  = mask_reg;
		req_next   = req_reg;
		cause_next = cause_reg;
		rdata_next = 8'h00;
		irq_evt    = 1'b0;
		// Register writes
		if (reg_wr) begin
			if (reg_addr == lvd_pkg::ADDR_CTRL) begin
				on_next   = reg_wdata[lvd_pkg::BIT_ON];
				mode_next = reg_wdata[lvd_pkg::BIT_MODE];
				src_next  = reg_wdata[lvd_pkg::BIT_SOURCE];
			end else if (reg_addr == lvd_pkg::ADDR_LEVEL) begin
				level_next = reg_wdata[3:0];
			end else if (reg_addr == lvd_pkg::ADDR_IRQ) begin
				mask_next = reg_wdata[lvd_pkg::BIT_MASK];
				req_next  = reg_wdata[lvd_pkg::BIT_REQ];
			end else if (reg_addr == lvd_pkg::ADDR_CAUSE) begin
				cause_next = cause_reg & ~reg_wdata[lvd_pkg::BIT_CAUSE];
			end
		end
		// Interrupt events: both crossings while on, or disable while below
		if (on_reg && !mode_reg && (cmp.fall_evt || cmp.rise_evt)) begin
			irq_evt = 1'b1;
		end else if (on_reg && !mode_reg && !on_next && cmp.below) begin
			irq_evt = 1'b1;
		end
		// Set wins over a clear in the same cycle
		if (irq_evt) begin
			req_next = 1'b1;
		end
		// Reads
		if (reg_rd) begin
			if (reg_addr == lvd_pkg::ADDR_CTRL) begin
				rdata_next = {on_reg, 4'h0, src_reg, mode_reg,
					on_reg & cmp.below};
			end else if (reg_addr == lvd_pkg::ADDR_LEVEL) begin
				rdata_next = {4'h0, level_reg};
			end else if (reg_addr == lvd_pkg::ADDR_IRQ) begin
				rdata_next = {6'h00, mask_reg, req_reg};
			end else if (reg_addr == lvd_pkg::ADDR_CAUSE) begin
				rdata_next = {7'h00, cause_reg};
			end
		end
		// Reset level follows the comparator, never fires when above
		rst_next = on_reg & mode_reg & cmp.below;
		irq_next = irq_evt & ~mask_reg;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// Non-detector reset clears everything
			on_reg    <= 1'b0;
			mode_reg  <= 1'b0;
			src_reg   <= 1'b0;
			level_reg <= lvd_pkg::LEVEL_RESET;
			cause_reg <= 1'b0;
		end else if (lowv_reset_in) begin
			// Detector reset keeps control and level, records the cause
			cause_reg <= 1'b1;
		end else begin
			on_reg    <= on_next;
			mode_reg  <= mode_next;
			src_reg   <= src_next;
			level_reg <= level_next;
			cause_reg <= cause_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (any_rst) begin
			mask_reg  <= lvd_pkg::MASK_RESET;
			req_reg   <= 1'b0;
			irq_reg   <= 1'b0;
			rst_reg   <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			mask_reg  <= mask_next;
			req_reg   <= req_next;
			irq_reg   <= irq_next;
			rst_reg   <= rst_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata        = rdata_reg;
	assign supply_threshold = level_reg;
	assign cmp_enable       = on_reg;
	assign lowv_reset_req   = rst_reg;
	assign lowv_irq         = irq_reg;

	// ****************************************
	// Assertions
	// ****************************************
	// Below in reset mode raises the reset one cycle later
	a_reset_follows: assert property (@(posedge mclk) disable iff (any_rst)
		(on_reg && mode_reg && cmp.below) |=> lowv_reset_req)
		else $error("Reset not asserted while below");

	// Pin source in reset mode holds the reset as well
	a_reset_pin: assert property (@(posedge mclk) disable iff (any_rst)
		(on_reg && mode_reg && src_reg && cmp.below) |=> lowv_reset_req)
		else $error("Pin source did not hold reset");

	// Level back at or above threshold lets the reset go
	a_no_reset_above: assert property (@(posedge mclk) disable iff (any_rst)
		(!cmp.below) |=> !lowv_reset_req)
		else $error("Reset asserted while above");

	// Reset request only with the detector on in reset mode
	a_reset_gated: assert property (@(posedge mclk) disable iff (any_rst)
		(!on_reg || !mode_reg) |=> !lowv_reset_req)
		else $error("Reset request outside reset mode");

	// Rising crossing sets the request flag
	a_edge_irq: assert property (@(posedge mclk) disable iff (any_rst)
		(on_reg && !mode_reg && cmp.rise_evt) |=> req_reg)
		else $error("Crossing did not set request");

	// Falling crossing sets the request flag too
	a_fall_irq: assert property (@(posedge mclk) disable iff (any_rst)
		(on_reg && !mode_reg && cmp.fall_evt) |=> req_reg)
		else $error("Falling crossing did not set request");

	// Unmasked crossing reaches the interrupt output
	a_irq_unmasked: assert property (@(posedge mclk) disable iff (any_rst)
		(on_reg && !mode_reg && !mask_reg && (cmp.fall_evt || cmp.rise_evt))
		|=> lowv_irq)
		else $error("Unmasked crossing gave no interrupt");

	// Reset mode or a stopped detector never interrupts
	a_irq_mode_only: assert property (@(posedge mclk) disable iff (any_rst)
		(mode_reg || !on_reg) |=> !lowv_irq)
		else $error("Interrupt outside interrupt mode");

	// Request flag only drops by a write of its register
	a_req_sticky: assert property (@(posedge mclk) disable iff (any_rst)
		(req_reg && !(reg_wr && reg_addr == lvd_pkg::ADDR_IRQ)) |=> req_reg)
		else $error("Request flag dropped by itself");

	// Switch-off while below leaves a request behind
	a_off_below: assert property (@(posedge mclk) disable iff (any_rst)
		(on_reg && !mode_reg && cmp.below && !on_next) |=> req_reg && !on_reg)
		else $error("Disable while below lost interrupt");

	// Flag bit reads the settled level, gated by the enable
	a_flag_read: assert property (@(posedge mclk) disable iff (any_rst)
		(reg_rd && reg_addr == lvd_pkg::ADDR_CTRL) |=>
		reg_rdata[0] == ($past(on_reg) & $past(cmp.below)))
		else $error("Level flag read wrong");

	// Read data is zero outside the answer cycle
	a_rdata_idle: assert property (@(posedge mclk) disable iff (any_rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("Read data outside answer cycle");

	// Control write lands in its three fields
	a_ctrl_write: assert property (@(posedge mclk) disable iff (any_rst)
		(reg_wr && reg_addr == lvd_pkg::ADDR_CTRL) |=>
		on_reg == $past(reg_wdata[lvd_pkg::BIT_ON]) &&
		mode_reg == $past(reg_wdata[lvd_pkg::BIT_MODE]) &&
		src_reg == $past(reg_wdata[lvd_pkg::BIT_SOURCE]))
		else $error("Control write misplaced");

	// Level write reaches the comparator
	a_level_write: assert property (@(posedge mclk) disable iff (any_rst)
		(reg_wr && reg_addr == lvd_pkg::ADDR_LEVEL) |=>
		supply_threshold == $past(reg_wdata[3:0]))
		else $error("Level code not taken");

	// Mask hides every request from the output
	a_irq_masked: assert property (@(posedge mclk) disable iff (any_rst)
		mask_reg |=> !lowv_irq)
		else $error("Masked interrupt escaped");

	// Any reset leaves the interrupt masked
	a_mask_reset: assert property (@(posedge mclk)
		any_rst |=> mask_reg)
		else $error("Mask not set by reset");

	// Detector reset is recorded
	a_cause_set: assert property (@(posedge mclk) disable iff (sys_rst)
		lowv_reset_in |=> cause_reg)
		else $error("Cause not recorded");

	// Other resets clear the recorded cause
	a_cause_clear: assert property (@(posedge mclk)
		sys_rst |=> !cause_reg)
		else $error("Other reset left cause set");

	// Detector reset keeps mode and source
	a_mode_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		lowv_reset_in |=> $stable(mode_reg) && $stable(src_reg))
		else $error("Detector reset altered mode or source");

	// Detector reset keeps level and enable
	a_level_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		lowv_reset_in |=> $stable(level_reg) && $stable(on_reg))
		else $error("Detector reset altered settings");

	// Other resets clear level, enable and mode
	a_level_clear: assert property (@(posedge mclk)
		sys_rst |=> level_reg == 4'h0 && !on_reg && !mode_reg)
		else $error("Other reset left settings");

	// ****************************************
	// Cover points
	// ****************************************
	// Reset mode fired
	c_reset_mode: cover property (@(posedge mclk) lowv_reset_req);
	// Reset mode fired from the pin
	c_pin_reset: cover property (@(posedge mclk) src_reg && lowv_reset_req);
	// Interrupt delivered
	c_irq: cover property (@(posedge mclk) lowv_irq);
	// Switch-off while below
	c_off_below: cover property (@(posedge mclk) on_reg && cmp.below && !on_next);
	// Detector-caused reset seen
	c_cause: cover property (@(posedge mclk) lowv_reset_in);
endmodule

/* design/lvd_pkg.sv */
// Package: register map, field positions and reset values of the low-voltage detect control
package lvd_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [3:0] ADDR_CTRL  = 4'h0;  // Detection control register
	localparam logic [3:0] ADDR_LEVEL = 4'h1;  // Level-select register
	localparam logic [3:0] ADDR_IRQ   = 4'h2;  // Interrupt mask and request flag
	localparam logic [3:0] ADDR_CAUSE = 4'h3;  // Reset-cause register

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_FLAG    = 0;  // Below-level flag, read only
	localparam int BIT_MODE    = 1;  // Reset-not-interrupt select
	localparam int BIT_SOURCE  = 2;  // Sense source select
	localparam int BIT_ON      = 7;  // Detector on
	localparam int BIT_REQ     = 0;  // Interrupt request flag in irq register
	localparam int BIT_MASK    = 1;  // Interrupt mask in irq register
	localparam int BIT_CAUSE   = 0;  // Detector reset cause

	// ****************************************
	// Reset values and widths
	// ****************************************
	localparam int DATA_W               = 8;       // Register data width
	localparam int LEVEL_W              = 4;       // Level code width
	localparam logic [3:0] LEVEL_RESET  = 4'h0;    // Level code after reset
	localparam logic       MASK_RESET   = 1'b1;    // Interrupt starts masked
	localparam int SYNC_STAGES          = 2;       // Comparator synchroniser depth

	// Comparator stabilisation time, software waits it out
	localparam int STAB_NS     = 10000;
	localparam int CLK_NS      = 25;
	localparam int STAB_CYCLES = (STAB_NS + CLK_NS - 1) / CLK_NS;

	// Operating mode of the detector
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_IRQ,
		MODE_RESET
	} lvd_mode_t;

endpackage

/* design/lvd_cmp_if.sv */
// Interface: synchronised comparator result and its edge events
interface lvd_cmp_if;
	logic below;     // Synchronised below-threshold level
	logic fall_evt;  // Voltage went below threshold (one cycle)
	logic rise_evt;  // Voltage went back to or above threshold (one cycle)
	modport src (output below, output fall_evt, output rise_evt);
	modport dst (input below, input fall_evt, input rise_evt);
endinterface

/* design/lvd_sync.sv */
// Synchroniser and edge detector for the analog comparator output
module lvd_sync #(
	parameter int STAGES = lvd_pkg::SYNC_STAGES
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// Raw comparator
	input  wire logic cmp_raw,
	// Clean result
	lvd_cmp_if.src    cmp
);
	// Elaboration check: one stage leaves the level no time to settle
	if (STAGES < 2) begin : g_bad_stages
		$error("lvd_sync needs at least two stages");
	end

	// ****************************************
	// Chain and edge state
	// ****************************************
	logic [STAGES-1:0] chain_reg;   // Synchroniser chain
	logic [STAGES-1:0] chain_next;
	logic              last_reg;    // Previous clean level
	logic              last_next;

	// Shift the chain; only the last stage is looked at
	always_comb begin
		chain_next = {chain_reg[STAGES-2:0], cmp_raw};
		last_next  = chain_reg[STAGES-1];
	end

	// Register the chain
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			chain_reg <= '0;
			last_reg  <= 1'b0;
		end else begin
			chain_reg <= chain_next;
			last_reg  <= last_next;
		end
	end

	// Level and edges from settled stages only
	assign cmp.below    = chain_reg[STAGES-1];
	assign cmp.fall_evt = chain_reg[STAGES-1] & ~last_reg;
	assign cmp.rise_evt = ~chain_reg[STAGES-1] & last_reg;

	// Edge events come in the same cycle as the settled level change
	a_fall_edge: assert property (@(posedge mclk) disable iff (sys_rst)
		cmp.fall_evt |-> cmp.below && !$past(cmp.below))
		else $error("Falling event without level change");
endmodule

/* testbench/lvd_cmp_model.sv */
// Behavioural model of the supply and sense-pin comparators beside the detector
module lvd_cmp_model #(
	parameter int SETTLE = 8  // Cycles of chatter after switch-on
) (
	// Clock
	input  wire logic       mclk,
	// From the detector
	input  wire logic       cmp_enable,
	input  wire logic [3:0] supply_threshold,
	// Analog conditions, drop counts in level steps
	input  wire logic [4:0] supply_drop,
	input  wire logic       ext_below,
	// Comparator results, 1 = below
	output logic            supply_below_raw,
	output logic            ext_sense_pin_below_raw
);
	timeunit 1ns;
	timeprecision 1ps;

	int unsigned age = 0;  // Cycles since switch-on

	// Settling counter, restarts at every switch-on
	always @(posedge mclk) begin
		age <= cmp_enable ? age + 1 : 0;
	end

	// Off reads not-below; a fresh comparator chatters, so waiting is not optional
	always_comb begin
		if (!cmp_enable) begin
			supply_below_raw        = 1'b0;
			ext_sense_pin_below_raw = 1'b0;
		end else if (age < SETTLE) begin
			supply_below_raw        = age[0];
			ext_sense_pin_below_raw = age[0];
		end else begin
			supply_below_raw        = supply_drop > {1'b0, supply_threshold};
			ext_sense_pin_below_raw = ext_below;
		end
	end
endmodule

/* testbench/tb_lvd_ctrl.sv */
// Self-checking bench of the low-voltage detect control
module tb_lvd_ctrl;
	timeunit 1ns;
	timeprecision 1ps;

	// ********************
	// Signals and table
	// ********************
	logic       mclk = 1'b0, sys_rst = 1'b1, lowv_reset_in = 1'b0, reg_wr = 1'b0;
	logic       reg_rd = 1'b0, ext_below = 1'b0, cmp_enable, lowv_reset_req, lowv_irq;
	logic       supply_below_raw, ext_sense_pin_below_raw;
	logic [3:0] reg_addr = 4'h0, supply_threshold;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [4:0] supply_drop = 5'h00;  // Supply below code when drop exceeds it
	int         n_fail = 0, n_compared = 0;
	// Row: optional write, then the value that a read must return
	typedef struct {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] e;} lvd_row_t;
	lvd_row_t rows [9] = '{
		'{lvd_pkg::ADDR_CTRL, 1'b0, 8'h00, 8'h00}, '{lvd_pkg::ADDR_LEVEL, 1'b0, 8'h00, 8'h00},
		'{lvd_pkg::ADDR_IRQ, 1'b0, 8'h00, 8'h02}, '{lvd_pkg::ADDR_CAUSE, 1'b0, 8'h00, 8'h00},
		'{4'h9, 1'b1, 8'hab, 8'h00}, '{lvd_pkg::ADDR_LEVEL, 1'b1, 8'h0f, 8'h0f},
		'{lvd_pkg::ADDR_CTRL, 1'b1, 8'h7e, 8'h06}, '{lvd_pkg::ADDR_CTRL, 1'b1, 8'h00, 8'h00},
		'{lvd_pkg::ADDR_IRQ, 1'b1, 8'h01, 8'h01}};

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	// Device and its comparators
	lvd_ctrl i_dut (.mclk(mclk), .sys_rst(sys_rst), .lowv_reset_in(lowv_reset_in),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .supply_below_raw(supply_below_raw),
		.ext_sense_pin_below_raw(ext_sense_pin_below_raw),
		.supply_threshold(supply_threshold), .cmp_enable(cmp_enable),
		.lowv_reset_req(lowv_reset_req), .lowv_irq(lowv_irq));
	lvd_cmp_model i_cmp (.mclk(mclk), .cmp_enable(cmp_enable),
		.supply_threshold(supply_threshold), .supply_drop(supply_drop),
		.ext_below(ext_below), .supply_below_raw(supply_below_raw),
		.ext_sense_pin_below_raw(ext_sense_pin_below_raw));

	// ********************
	// Tasks
	// ********************
	// Verdict, the only exit
	task automatic close_out();
		if (n_fail == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Register value compare
	task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	// Output level compare
	task automatic chk_bit(logic got, logic exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: output %b, expected %b", $time, got, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read, data looked at only in the cycle after the strobe
	task automatic rd_chk(logic [3:0] a, logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk_reg(reg_rdata, e);
	endtask
	// Select reset request (0) or interrupt (1)
	function automatic logic pick(bit s);
		return s ? lowv_irq : lowv_reset_req;
	endfunction
	// Bounded wait; a pulse is caught since each cycle is looked at
	task automatic wait_for(bit s, logic v);
		for (int i = 0; i < 12; i++) begin
			@(negedge mclk);
			if (pick(s) === v) begin
				n_compared++;
				return;
			end
		end
		n_fail++;
		$display("mismatch at %0t: output never reached %b", $time, v);
		close_out();
	endtask
	// Output must stay low
	task automatic hold_low(bit s, int n);
		repeat (n) begin
			@(negedge mclk);
			chk_bit(pick(s), 1'b0);
		end
	endtask
	// Masked start-up: mask, control value, wait out settling
	task automatic start(logic [7:0] c);
		wr(lvd_pkg::ADDR_IRQ, 8'h02);
		wr(lvd_pkg::ADDR_CTRL, c);
		repeat (lvd_pkg::STAB_CYCLES) @(posedge mclk);
	endtask

	// ********************
	// Sequence
	// ********************
	initial begin
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
			end
			rd_chk(rows[i].a, rows[i].e);
		end
		// Reset mode on the supply, boundary drop equal to the code
		wr(lvd_pkg::ADDR_LEVEL, 8'h03);
		start(8'h80);
		rd_chk(lvd_pkg::ADDR_CTRL, 8'h80);
		chk_bit(cmp_enable, 1'b1);
		chk_reg({4'h0, supply_threshold}, 8'h03);
		wr(lvd_pkg::ADDR_CTRL, 8'h82);
		hold_low(0, 8);
		@(posedge mclk) supply_drop <= 5'h04;
		wait_for(0, 1'b1);
		rd_chk(lvd_pkg::ADDR_CTRL, 8'h83);
		@(posedge mclk) supply_drop <= 5'h03;
		wait_for(0, 1'b0);
		// Detector-caused reset keeps setup, records cause
		@(posedge mclk) lowv_reset_in <= 1'b1;
		@(posedge mclk) lowv_reset_in <= 1'b0;
		rd_chk(lvd_pkg::ADDR_CAUSE, 8'h01);
		rd_chk(lvd_pkg::ADDR_CTRL, 8'h82);
		rd_chk(lvd_pkg::ADDR_LEVEL, 8'h03);
		rd_chk(lvd_pkg::ADDR_IRQ, 8'h02);
		wr(lvd_pkg::ADDR_CAUSE, 8'h01);
		rd_chk(lvd_pkg::ADDR_CAUSE, 8'h00);
		wr(lvd_pkg::ADDR_CTRL, 8'h80);
		wr(lvd_pkg::ADDR_CTRL, 8'h00);
		// Reset mode on the sense pin
		start(8'h84);
		wr(lvd_pkg::ADDR_CTRL, 8'h86);
		@(posedge mclk) ext_below <= 1'b1;
		wait_for(0, 1'b1);
		@(posedge mclk) ext_below <= 1'b0;
		wait_for(0, 1'b0);
		wr(lvd_pkg::ADDR_CTRL, 8'h00);
		// Interrupt mode on the supply, chatter hidden by the mask
		wr(lvd_pkg::ADDR_IRQ, 8'h02);
		wr(lvd_pkg::ADDR_CTRL, 8'h80);
		hold_low(1, 16);
		repeat (lvd_pkg::STAB_CYCLES) @(posedge mclk);
		wr(lvd_pkg::ADDR_IRQ, 8'h00);
		@(posedge mclk) supply_drop <= 5'h04;
		wait_for(1, 1'b1);
		rd_chk(lvd_pkg::ADDR_IRQ, 8'h01);
		wr(lvd_pkg::ADDR_IRQ, 8'h00);
		@(posedge mclk) supply_drop <= 5'h00;
		wait_for(1, 1'b1);
		hold_low(1, 4);
		// Interrupt mode on the pin, then switch-off while below
		start(8'h84);
		wr(lvd_pkg::ADDR_IRQ, 8'h00);
		@(posedge mclk) ext_below <= 1'b1;
		wait_for(1, 1'b1);
		wr(lvd_pkg::ADDR_IRQ, 8'h00);
		wr(lvd_pkg::ADDR_CTRL, 8'h04);
		wait_for(1, 1'b1);
		rd_chk(lvd_pkg::ADDR_IRQ, 8'h01);
		// Ordinary reset in mid-run clears the setup
		@(posedge mclk) sys_rst <= 1'b1;
		@(posedge mclk) sys_rst <= 1'b0;
		rd_chk(lvd_pkg::ADDR_CTRL, 8'h00);
		rd_chk(lvd_pkg::ADDR_LEVEL, 8'h00);
		rd_chk(lvd_pkg::ADDR_IRQ, 8'h02);
		chk_bit(cmp_enable, 1'b0);
		chk_reg({4'h0, supply_threshold}, 8'h00);
		close_out();
	end
endmodule
